// ==== pkg/erpo_pkg.sv ====
// constants and carrier types of the receive payload output and interrupt block
package erpo_pkg;

  // ==========================================================================
  // register map: printed offsets are indices, byte address is four times
  localparam int IDX_BLOCK_IRQ_EN = 8'h04;
  localparam int IDX_RX_CFG_STAT2 = 8'h11;
  localparam int IDX_RX_IRQ_EN1 = 8'h12;
  localparam int IDX_RX_IRQ_EN2 = 8'h13;
  localparam int IDX_RX_IRQ_STAT1 = 8'h14;
  localparam int IDX_RX_IRQ_STAT2 = 8'h15;
  localparam logic [7:0] ADDR_BLOCK_IRQ_EN = 8'(4 * IDX_BLOCK_IRQ_EN);
  localparam logic [7:0] ADDR_RX_CFG_STAT2 = 8'(4 * IDX_RX_CFG_STAT2);
  localparam logic [7:0] ADDR_RX_IRQ_EN1 = 8'(4 * IDX_RX_IRQ_EN1);
  localparam logic [7:0] ADDR_RX_IRQ_EN2 = 8'(4 * IDX_RX_IRQ_EN2);
  localparam logic [7:0] ADDR_RX_IRQ_STAT1 = 8'(4 * IDX_RX_IRQ_STAT1);
  localparam logic [7:0] ADDR_RX_IRQ_STAT2 = 8'(4 * IDX_RX_IRQ_STAT2);

  // ==========================================================================
  // field positions
  localparam int BIT_RX_BLOCK_EN = 7;
  localparam int BIT_TX_BLOCK_EN = 1;
  localparam int BIT_ONE_SEC_EN = 0;
  localparam int BIT_CFG_LOS = 4;
  localparam int BIT_LOS_SRC = 1;
  localparam int SRC_PER_REG = 5;
  localparam int NUM_SRC = 2 * SRC_PER_REG;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_BLOCK_IRQ_EN = 8'h00;
  localparam logic [SRC_PER_REG-1:0] RST_IRQ_EN = 5'h00;
  localparam logic [NUM_SRC-1:0] RST_IRQ_STAT = 10'h000;

  // ==========================================================================
  // signal-loss detection counts
  localparam int LOS_ZERO_RUN = 32;
  localparam int LOS_GOOD_BITS = 32;
  localparam int LOS_BAD_RUN = 4;

  // ==========================================================================
  // payload timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int E3_BIT_PS = 29097;
  localparam int NIBBLES_PER_FRAME = 1060;
  localparam int SER_HIGH_CYC_I = (E3_BIT_PS / 2) / CLK_PERIOD_PS;
  localparam int NIB_HIGH_CYC_I = E3_BIT_PS / CLK_PERIOD_PS;
  localparam logic [3:0] SER_HIGH_CYC =
    4'((SER_HIGH_CYC_I < 1) ? 1 : SER_HIGH_CYC_I);
  localparam logic [3:0] NIB_HIGH_CYC =
    4'((NIB_HIGH_CYC_I < 1) ? 1 : NIB_HIGH_CYC_I);

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic data;
    logic overhead;
    logic frameStart;
  } erpo_rx_bit_type;

  typedef struct packed {
    logic receivePayloadClock;
    logic serialPayloadOut;
    logic [3:0] nibblePayloadBus;
    logic frameStartOut;
    logic overheadBitFlag;
  } erpo_payload_type;

  typedef struct packed {
    logic farEndBlockError;
    logic bip4Error;
    logic framingError;
    logic lapdMessage;
    logic farEndFailureChange;
    logic framingAlignmentChange;
    logic outOfFrameChange;
    logic frameLossChange;
    logic alarmIndicationChange;
  } erpo_events_type;

endpackage

// ==== logic/erpo_top.sv ====
// receive payload output interface, signal-loss detector and rx interrupts
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module erpo_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lineClock,
  input wire logic linePositiveInput,
  input wire logic lineNegativeInput,
  input wire logic lineInterfaceLossInput,
  input wire logic nibbleModeSelect,
  input wire erpo_pkg::erpo_rx_bit_type rxBit,
  input wire erpo_pkg::erpo_events_type framerEvents,
  output erpo_pkg::erpo_payload_type payloadOut,
  output logic signalLossCondition,
  output logic irq_n
);
  import erpo_pkg::*;

  // ==========================================================================
  // reset release and pin synchronisers
  logic [1:0] rstSync;
  logic rstN;
  logic [1:0] syncLineClk, syncPos, syncNeg, syncLoss, syncMode;
  logic lineClkDly, lossDly;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      syncLineClk <= 2'b00;
      syncPos <= 2'b00;
      syncNeg <= 2'b00;
      syncLoss <= 2'b00;
      syncMode <= 2'b00;
      lineClkDly <= 1'b0;
      lossDly <= 1'b0;
    end else begin
      syncLineClk <= {syncLineClk[0], lineClock};
      syncPos <= {syncPos[0], linePositiveInput};
      syncNeg <= {syncNeg[0], lineNegativeInput};
      syncLoss <= {syncLoss[0], lineInterfaceLossInput};
      syncMode <= {syncMode[0], nibbleModeSelect};
      lineClkDly <= syncLineClk[1];
      lossDly <= syncLoss[1];
    end
  end

  // ==========================================================================
  // signal-loss detector
  logic lineEdge, lineZero, lossRise, lossFall;
  logic [5:0] zeroRun, next_zeroRun;
  logic [5:0] goodCnt, next_goodCnt;
  logic losCond, next_losCond;

  assign lineEdge = syncLineClk[1] & ~lineClkDly;
  assign lineZero = ~syncPos[1] & ~syncNeg[1];
  assign lossRise = syncLoss[1] & ~lossDly;
  assign lossFall = ~syncLoss[1] & lossDly;

  always_comb begin
    next_zeroRun = zeroRun;
    next_goodCnt = goodCnt;
    next_losCond = losCond;
    if (lineEdge) begin
      if (lineZero) begin
        if (zeroRun < 6'(LOS_ZERO_RUN)) begin
          next_zeroRun = zeroRun + 6'd1;
        end
      end else begin
        next_zeroRun = 6'd0;
      end
      if (lineZero && zeroRun >= 6'(LOS_BAD_RUN - 1)) begin
        next_goodCnt = 6'd0;
      end else if (goodCnt < 6'(LOS_GOOD_BITS)) begin
        next_goodCnt = goodCnt + 6'd1;
      end
    end
    if (lossRise || next_zeroRun == 6'(LOS_ZERO_RUN)) begin
      next_losCond = 1'b1;
    end else if (lossFall) begin
      next_losCond = 1'b0;
    end else if (!syncLoss[1] && next_goodCnt == 6'(LOS_GOOD_BITS)) begin
      next_losCond = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      zeroRun <= 6'd0;
      goodCnt <= 6'd0;
      losCond <= 1'b0;
    end else begin
      zeroRun <= next_zeroRun;
      goodCnt <= next_goodCnt;
      losCond <= next_losCond;
    end
  end
  assign signalLossCondition = losCond;

  // ==========================================================================
  // payload output interface
  erpo_payload_type pay, next_pay;
  logic [3:0] highCnt, next_highCnt;
  logic [1:0] nibCnt, next_nibCnt;
  logic [2:0] nibAcc, next_nibAcc;
  logic frmPend, next_frmPend;
  logic nibMode;

  assign nibMode = syncMode[1];

  always_comb begin
    next_pay = pay;
    next_highCnt = highCnt;
    next_nibCnt = nibCnt;
    next_nibAcc = nibAcc;
    next_frmPend = frmPend;
    if (highCnt != 4'd0) begin
      next_highCnt = highCnt - 4'd1;
    end
    if (!nibMode) begin
      next_nibCnt = 2'd0;
      next_frmPend = 1'b0;
      if (rxBit.valid) begin
        next_pay.serialPayloadOut = rxBit.data;
        next_pay.frameStartOut = rxBit.frameStart;
        next_pay.overheadBitFlag = rxBit.overhead;
        next_highCnt = SER_HIGH_CYC;
      end
    end else begin
      next_pay.overheadBitFlag = 1'b0;
      next_pay.serialPayloadOut = 1'b0;
      if (rxBit.valid) begin
        if (rxBit.frameStart) begin
          next_frmPend = 1'b1;
          next_nibCnt = 2'd0;
        end
        if (!rxBit.overhead) begin
          // 4240 payload bits per frame give 1060 strobes
          if (next_nibCnt == 2'd3) begin
            next_pay.nibblePayloadBus = {nibAcc, rxBit.data};
            next_pay.frameStartOut =
              next_frmPend | rxBit.frameStart;
            next_frmPend = 1'b0;
            next_highCnt = NIB_HIGH_CYC;
            next_nibCnt = 2'd0;
          end else begin
            next_nibAcc = {next_nibAcc[1:0], rxBit.data};
            next_nibCnt = next_nibCnt + 2'd1;
          end
        end
      end
    end
    // clock rises with each data update, falls after the high time
    next_pay.receivePayloadClock = (next_highCnt != 4'd0);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pay <= '0;
      highCnt <= 4'd0;
      nibCnt <= 2'd0;
      nibAcc <= 3'd0;
      frmPend <= 1'b0;
    end else begin
      pay <= next_pay;
      highCnt <= next_highCnt;
      nibCnt <= next_nibCnt;
      nibAcc <= next_nibAcc;
      frmPend <= next_frmPend;
    end
  end
  assign payloadOut = pay;

  // ==========================================================================
  // interrupt sources, enables and read-to-clear status
  logic [7:0] blockEn, next_blockEn;
  logic [SRC_PER_REG-1:0] en1, next_en1, en2, next_en2;
  logic [NUM_SRC-1:0] stat, next_stat, srcEvt, clrMask, srcEn;
  logic losChange;
  logic irqReq, next_irqReq;

  assign losChange = next_losCond ^ losCond;
  assign srcEvt = {framerEvents.lapdMessage, framerEvents.framingError,
                   framerEvents.bip4Error, framerEvents.farEndBlockError,
                   framerEvents.farEndFailureChange,
                   framerEvents.framingAlignmentChange,
                   framerEvents.outOfFrameChange,
                   framerEvents.frameLossChange, losChange,
                   framerEvents.alarmIndicationChange};
  assign srcEn = {en2, en1};

  // ==========================================================================
  // apb slave, zero wait states
  logic setup, access, wrAcc, rdSetup, mapped;
  logic [31:0] next_prdata;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wrAcc = access & pwrite;
  assign rdSetup = setup & ~pwrite;
  assign mapped = (paddr == ADDR_BLOCK_IRQ_EN) ||
                  (paddr == ADDR_RX_CFG_STAT2) ||
                  (paddr == ADDR_RX_IRQ_EN1) ||
                  (paddr == ADDR_RX_IRQ_EN2) ||
                  (paddr == ADDR_RX_IRQ_STAT1) ||
                  (paddr == ADDR_RX_IRQ_STAT2);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  always_comb begin
    next_prdata = prdata;
    clrMask = '0;
    if (rdSetup) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        ADDR_BLOCK_IRQ_EN: next_prdata[7:0] = blockEn;
        ADDR_RX_CFG_STAT2: next_prdata[BIT_CFG_LOS] = losCond;
        ADDR_RX_IRQ_EN1: next_prdata[SRC_PER_REG-1:0] = en1;
        ADDR_RX_IRQ_EN2: next_prdata[SRC_PER_REG-1:0] = en2;
        ADDR_RX_IRQ_STAT1:
          next_prdata[SRC_PER_REG-1:0] = stat[SRC_PER_REG-1:0];
        ADDR_RX_IRQ_STAT2:
          next_prdata[SRC_PER_REG-1:0] = stat[NUM_SRC-1:SRC_PER_REG];
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    if (access && !pwrite && paddr == ADDR_RX_IRQ_STAT1) begin
      clrMask[SRC_PER_REG-1:0] = prdata[SRC_PER_REG-1:0];
    end
    if (access && !pwrite && paddr == ADDR_RX_IRQ_STAT2) begin
      clrMask[NUM_SRC-1:SRC_PER_REG] = prdata[SRC_PER_REG-1:0];
    end
  end

  always_comb begin
    next_blockEn = blockEn;
    next_en1 = en1;
    next_en2 = en2;
    if (wrAcc && paddr == ADDR_BLOCK_IRQ_EN) begin
      next_blockEn = 8'h00;
      next_blockEn[BIT_RX_BLOCK_EN] = pwdata[BIT_RX_BLOCK_EN];
      next_blockEn[BIT_TX_BLOCK_EN] = pwdata[BIT_TX_BLOCK_EN];
      next_blockEn[BIT_ONE_SEC_EN] = pwdata[BIT_ONE_SEC_EN];
    end
    if (wrAcc && paddr == ADDR_RX_IRQ_EN1) begin
      next_en1 = pwdata[SRC_PER_REG-1:0];
    end
    if (wrAcc && paddr == ADDR_RX_IRQ_EN2) begin
      next_en2 = pwdata[SRC_PER_REG-1:0];
    end
    // only reported bits clear; a fresh event in the same cycle wins
    next_stat = (stat & ~clrMask) | (srcEvt & srcEn);
    next_irqReq = blockEn[BIT_RX_BLOCK_EN] & |(stat & srcEn);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      blockEn <= RST_BLOCK_IRQ_EN;
      en1 <= RST_IRQ_EN;
      en2 <= RST_IRQ_EN;
      stat <= RST_IRQ_STAT;
      irqReq <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      blockEn <= next_blockEn;
      en1 <= next_en1;
      en2 <= next_en2;
      stat <= next_stat;
      irqReq <= next_irqReq;
      prdata <= next_prdata;
    end
  end
  assign irq_n = ~irqReq;

endmodule

// ==== verification/erpo_top_checker.sv ====
// assertions on payload output and rx interrupt behaviour
`timescale 1ns/1ps
module erpo_top_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic lineInterfaceLossInput,
  input wire logic nibbleModeSelect,
  input wire erpo_pkg::erpo_rx_bit_type rxBit,
  input wire erpo_pkg::erpo_payload_type payloadOut,
  input wire logic signalLossCondition,
  input wire logic irq_n
);
  import erpo_pkg::*;
  // ==========
  // shadow of the enables
  logic rxEn;
  logic losEn;
  logic next_rxEn;
  logic next_losEn;
  logic wr;
  logic rpc;
  assign rpc = payloadOut.receivePayloadClock;
  assign wr = psel && penable && pwrite;
  always_comb begin
    next_rxEn = rxEn;
    next_losEn = losEn;
    if (wr && paddr == ADDR_BLOCK_IRQ_EN) begin
      next_rxEn = pwdata[BIT_RX_BLOCK_EN];
    end
    if (wr && paddr == ADDR_RX_IRQ_EN1) begin
      next_losEn = pwdata[BIT_LOS_SRC];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxEn <= 1'b0;
      losEn <= 1'b0;
    end else begin
      rxEn <= next_rxEn;
      losEn <= next_losEn;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ser;
    !nibbleModeSelect && !$past(nibbleModeSelect, 4);
  endsequence
  sequence s_nib;
    nibbleModeSelect && $past(nibbleModeSelect, 4);
  endsequence
  sequence s_nibPulse;
    rpc[*7] ##1 !rpc;
  endsequence
  property p_serData;
    s_ser ##0 rxBit.valid |=>
      $rose(rpc) && payloadOut.serialPayloadOut == $past(rxBit.data);
  endproperty
  a_serData: assert property (p_serData)
    else $error("serial bit not shown at clock rise");
  property p_serFrame;
    s_ser ##0 rxBit.valid |=>
      payloadOut.frameStartOut == $past(rxBit.frameStart);
  endproperty
  a_serFrame: assert property (p_serFrame)
    else $error("frame start not aligned with bit");
  property p_ohFlag;
    s_ser ##0 rxBit.valid |=>
      payloadOut.overheadBitFlag == $past(rxBit.overhead);
  endproperty
  a_ohFlag: assert property (p_ohFlag)
    else $error("overhead flag wrong");
  property p_nibHigh;
    s_nib ##0 $rose(rpc) |-> s_nibPulse;
  endproperty
  a_nibHigh: assert property (p_nibHigh)
    else $error("nibble strobe high time wrong");
  property p_nibLow;
    s_nib |-> !payloadOut.overheadBitFlag && !payloadOut.serialPayloadOut;
  endproperty
  a_nibLow: assert property (p_nibLow)
    else $error("serial signals active in nibble mode");
  property p_blockGate;
    $fell(irq_n) |-> $past(rxEn);
  endproperty
  a_blockGate: assert property (p_blockGate)
    else $error("interrupt without block enable");
  property p_losIrq;
    $changed(signalLossCondition) && $past(losEn) && rxEn |->
      ##[1:4] !irq_n;
  endproperty
  a_losIrq: assert property (p_losIrq)
    else $error("loss change raised no interrupt");
  property p_losSet;
    $rose(lineInterfaceLossInput) |-> ##[1:8] signalLossCondition;
  endproperty
  a_losSet: assert property (p_losSet)
    else $error("loss not declared");
  property p_losClr;
    $fell(lineInterfaceLossInput) |-> ##[1:8] !signalLossCondition;
  endproperty
  a_losClr: assert property (p_losClr)
    else $error("loss not cleared");
endmodule

bind erpo_top erpo_top_checker i_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .lineInterfaceLossInput(lineInterfaceLossInput),
  .nibbleModeSelect(nibbleModeSelect), .rxBit(rxBit),
  .payloadOut(payloadOut), .signalLossCondition(signalLossCondition),
  .irq_n(irq_n)
);

// ==== verification/erpo_terminal_model.sv ====
// terminal equipment model capturing the receive payload outputs
`timescale 1ns/1ps
module erpo_terminal_model (
  input wire logic clk,
  input wire erpo_pkg::erpo_payload_type payloadOut,
  input wire logic nibbleModeSelect,
  output logic [15:0] strobes,
  output logic [15:0] payBits,
  output logic [15:0] frameMarks,
  output logic [3:0] lastNib
);
  import erpo_pkg::*;
  logic rpcQ = 1'b0;
  logic [15:0] nStrobe = 16'h0000;
  logic [15:0] nPay = 16'h0000;
  logic [15:0] nFrame = 16'h0000;
  logic [3:0] nib = 4'h0;
  assign strobes = nStrobe;
  assign payBits = nPay;
  assign frameMarks = nFrame;
  assign lastNib = nib;
  // capture on each rise of the payload clock
  always @(posedge clk) begin
    rpcQ <= payloadOut.receivePayloadClock;
    if (payloadOut.receivePayloadClock && !rpcQ) begin
      nStrobe <= nStrobe + 16'h0001;
      if (payloadOut.frameStartOut) begin
        nFrame <= nFrame + 16'h0001;
      end
      if (nibbleModeSelect) begin
        nib <= payloadOut.nibblePayloadBus;
      end else if (!payloadOut.overheadBitFlag) begin
        nPay <= nPay + 16'h0001;
      end
    end
  end
endmodule

// ==== verification/erpo_top_tb.sv ====
// self-checking bench for the rx payload output and interrupt block
`timescale 1ns/1ps
module erpo_top_tb;
  import erpo_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic lineClock = 1'b0;
  logic linePositiveInput = 1'b0;
  logic lineNegativeInput = 1'b0;
  logic lineDrive = 1'b1;
  logic lineBitNo = 1'b0;
  logic [2:0] zeroGap = 3'h0;
  logic [2:0] gapCnt = 3'h0;
  logic lineInterfaceLossInput = 1'b0;
  logic nibbleModeSelect = 1'b0;
  erpo_rx_bit_type rxBit = '0;
  erpo_events_type framerEvents = '0;
  erpo_payload_type payloadOut;
  logic signalLossCondition;
  logic irq_n;
  logic [15:0] strobes;
  logic [15:0] payBits;
  logic [15:0] frameMarks;
  logic [3:0] lastNib;
  logic [15:0] base;
  logic [31:0] rd;
  logic rdErr;
  int n_mismatch = 0;
  int cmp_count = 0;
  // rows: {data, overhead, frameStart} in, {serial, flag, frame} out
  logic [5:0] rows [6] = '{6'h2D, 6'h36, 6'h24, 6'h12, 6'h24, 6'h00};

  always #2 clk = ~clk;
  always #24 lineClock = ~lineClock;
  // one mark, then zeroGap zero bits
  always @(negedge lineClock) begin
    lineBitNo <= ~lineBitNo;
    gapCnt <= (gapCnt >= zeroGap) ? 3'h0 : gapCnt + 3'h1;
  end
  // marks on the rail picked by line bit parity, or silence
  always @(posedge clk) begin
    linePositiveInput <= lineDrive && gapCnt == 3'h0 && lineBitNo;
    lineNegativeInput <= lineDrive && gapCnt == 3'h0 && !lineBitNo;
  end

  erpo_top i_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lineClock(lineClock),
    .linePositiveInput(linePositiveInput),
    .lineNegativeInput(lineNegativeInput),
    .lineInterfaceLossInput(lineInterfaceLossInput),
    .nibbleModeSelect(nibbleModeSelect), .rxBit(rxBit),
    .framerEvents(framerEvents), .payloadOut(payloadOut),
    .signalLossCondition(signalLossCondition), .irq_n(irq_n)
  );
  erpo_terminal_model i_term (
    .clk(clk), .payloadOut(payloadOut), .nibbleModeSelect(nibbleModeSelect),
    .strobes(strobes), .payBits(payBits), .frameMarks(frameMarks),
    .lastNib(lastNib)
  );

  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic sendBit(input logic [2:0] b);
    @(posedge clk);
    rxBit <= {1'b1, b};
    @(posedge clk);
    rxBit <= '0;
    repeat (6) @(posedge clk);
  endtask
  task automatic waitLos(input logic v);
    for (int i = 0; i < 4000 && signalLossCondition !== v; i++) @(posedge clk);
    chk(signalLossCondition, v);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #300000;
    n_mismatch++;
    stop_test();
  end

  // ==========
  // sequence of tests
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rdChk(ADDR_BLOCK_IRQ_EN, 32'(RST_BLOCK_IRQ_EN));
    rdChk(ADDR_RX_IRQ_EN1, 32'h0);
    rdChk(8'hFC, 32'h0);
    chk(32'(rdErr), 32'h1);
    $display("test reset done");
    foreach (rows[i]) begin
      sendBit(rows[i][5:3]);
      chk({payloadOut.serialPayloadOut, payloadOut.overheadBitFlag,
           payloadOut.frameStartOut}, 32'(rows[i][2:0]));
    end
    chk(strobes, 32'h6);
    chk(payBits, 32'h4);
    chk(frameMarks, 32'h1);
    $display("test serial done");
    nibbleModeSelect <= 1'b1;
    repeat (8) @(posedge clk);
    base = strobes;
    for (int i = 0; i < 4 * NIBBLES_PER_FRAME; i++) begin
      if (i == 2000) sendBit(3'h2);
      sendBit({i % 4 != 1, 1'b0, i == 0});
    end
    chk(strobes - base, 32'(NIBBLES_PER_FRAME));
    chk(lastNib, 32'hB);
    chk(frameMarks, 32'h2);
    chk(payloadOut.overheadBitFlag, 32'h0);
    nibbleModeSelect <= 1'b0;
    repeat (8) @(posedge clk);
    $display("test nibble done");
    apb(1'b1, ADDR_BLOCK_IRQ_EN, 32'hFF);
    rdChk(ADDR_BLOCK_IRQ_EN, 32'h83);
    apb(1'b1, ADDR_BLOCK_IRQ_EN, 32'h0);
    apb(1'b1, ADDR_RX_IRQ_EN1, 32'hFF);
    rdChk(ADDR_RX_IRQ_EN1, 32'h1F);
    apb(1'b1, ADDR_RX_IRQ_EN2, 32'h1F);
    framerEvents <= '1;
    @(posedge clk);
    framerEvents <= '0;
    repeat (4) @(posedge clk);
    chk(irq_n, 32'h1);
    rdChk(ADDR_RX_IRQ_STAT1, 32'h1D);
    rdChk(ADDR_RX_IRQ_STAT2, 32'h1F);
    rdChk(ADDR_RX_IRQ_STAT2, 32'h0);
    $display("test events done");
    apb(1'b1, ADDR_BLOCK_IRQ_EN, 32'h80);
    lineInterfaceLossInput <= 1'b1;
    waitLos(1'b1);
    repeat (4) @(posedge clk);
    chk(irq_n, 32'h0);
    rdChk(ADDR_RX_CFG_STAT2, 32'h10);
    rdChk(ADDR_RX_IRQ_STAT1, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq_n, 32'h1);
    lineInterfaceLossInput <= 1'b0;
    waitLos(1'b0);
    repeat (4) @(posedge clk);
    chk(irq_n, 32'h0);
    rdChk(ADDR_RX_IRQ_STAT1, 32'h2);
    lineDrive <= 1'b0;
    waitLos(1'b1);
    repeat (4) @(posedge clk);
    chk(irq_n, 32'h0);
    $display("test loss done");
    rst_n <= 1'b0;
    @(posedge clk);
    chk(irq_n, 32'h1);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rdChk(ADDR_BLOCK_IRQ_EN, 32'h0);
    waitLos(1'b1);
    zeroGap <= 3'h4;
    lineDrive <= 1'b1;
    repeat (1200) @(posedge clk);
    chk(signalLossCondition, 32'h1);
    zeroGap <= 3'h3;
    waitLos(1'b0);
    rdChk(ADDR_RX_IRQ_STAT1, 32'h0);
    $display("test rerun done");
    stop_test();
  end
endmodule
